// File: hdl/tap_pkg.sv
/*
  Package for the boundary-scan test access port: instruction codes, register
  lengths, identification fields and state encoding.
  Shared by the tap_port module, its assertion checker and its bench.
*/
package tap_pkg;
  localparam int IR_LEN = 4;
  localparam int ID_LEN = 32;
  localparam int USER_LEN = 32;
  localparam int BSR_LEN = 8;
  localparam int PINS = 4;
  localparam int DBG_LEN = 8;
  localparam int CFG_LEN = 8;
  // opcodes; all-ones selects bypass, as does every code left unassigned
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_SAMPLE = 4'h1;
  localparam logic [3:0] OP_IDCODE = 4'h2;
  localparam logic [3:0] OP_USERCODE = 4'h3;
  localparam logic [3:0] OP_CFG = 4'h4;
  localparam logic [3:0] OP_ANALYZER = 4'h5;
  localparam logic [3:0] OP_BYPASS = 4'hf;
  // identification fields; values are arbitrary
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h1234;
  localparam logic [10:0] ID_MAKER = 11'h155;
  localparam logic [31:0] USER_RESET = 32'hffffffff;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SDS = 4'h3, CDR = 4'h2, SDR = 4'h6, E1D = 4'h7,
    PDR = 4'h5, E2D = 4'h4, UDR = 4'hc, SIS = 4'hd, CIR = 4'hf, SIR = 4'he,
    E1I = 4'ha, PIR = 4'hb, E2I = 4'h9, UIR = 4'h8
  } tap_state_t;
endpackage : tap_pkg

// File: hdl/tap_port.sv
/*
  Boundary-scan test access port: state machine, instruction register and the
  data registers it selects, with a small boundary register over a pin group.
  Assumes tck from the tester, trstn as the test reset, and that the core
  side on clk supplies configuration status and analyzer nodes.
  The link logic runs wholly on tck. tms and tdi are taken on its rising
  edge, and tdo moves on its falling edge. The core side runs on clk.
  Signals cross between the two domains only through two-flop
  synchronisers or a toggle handshake.
  The pin group, the core outputs and the probe word reach the capture
  logic only through two tck flops each. A capture therefore shows values
  that were at least two test clocks old.
  The configuration byte is held on cfgData from update onward. The core
  should take it on cfgStrobe, which follows the update by a few clk
  cycles. It must not be sampled at any other time.
  The core keeps configBusy high for as long as configuration runs. The
  boundary instructions and the configuration instruction fall back to
  bypass while it is high.
  The LARGEST parameter models the biggest family member. Only bypass and
  the analyzer instruction are left to it.
*/
// Contract
// - the state sequence and instruction behaviour follow the standard test port architecture.
// - boundary-scan instructions act only while unconfigured or configured, never during configuration.
// - sample/preload captures the pins without disturbing them and preloads an output pattern.
// - extest drives the boundary pattern onto outputs and captures inputs.
// - bypass puts one register stage between test input and output.
// - the user-code instruction shifts out a 32-bit user code register.
// - the identification instruction shifts out the identification register.
// - the identification word is version, part number, manufacturer and a final bit from the top down.
// - the lowest identification bit is always one and is shifted out first.
// - analyzer instructions observe internal nodes, and sample/preload serves the analyzer too; here the analyzer reads only its own probe register.
// - the largest family member offers only bypass and analyzer instructions.
`timescale 1ns/1ns
`default_nettype none
module tap_port
  import tap_pkg::*;
#(
  parameter bit LARGEST = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic trstn,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoEn,
  input wire logic [PINS-1:0] pinIn,
  input wire logic [PINS-1:0] coreOut,
  output logic [PINS-1:0] pinOut,
  input wire logic configBusy,
  input wire logic [DBG_LEN-1:0] probeNodes,
  output logic [CFG_LEN-1:0] cfgData,
  output logic cfgStrobe,
  output logic scanHold
);
  import tap_pkg::*;

  // ==========================================================
  // core clock domain: status toward the link
  // ==========================================================
  logic busyCore;
  logic [DBG_LEN-1:0] probeCore;
  // registered in clk so the link only ever sees flop outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busyCore <= 1'b0;
      probeCore <= '0;
    end else begin
      busyCore <= configBusy;
      probeCore <= probeNodes;
    end
  end

  // ==========================================================
  // link domain: synchronisers
  // ==========================================================
  logic busyMeta, busyTck;
  always_ff @(posedge tck or negedge trstn) begin
    if (!trstn) begin
      busyMeta <= 1'b0;
      busyTck <= 1'b0;
    end else begin
      busyMeta <= busyCore;
      busyTck <= busyMeta;
    end
  end

  // pins, core outputs and probe word pass two tck flops before capture;
  // the probe word is a snapshot, so bits moving mid-sample may skew
  logic [PINS-1:0] pinMeta, pinSync, coreMeta, coreSync;
  logic [DBG_LEN-1:0] probeMeta, probeSync;
  always_ff @(posedge tck or negedge trstn) begin
    if (!trstn) begin
      pinMeta <= '0;
      pinSync <= '0;
      coreMeta <= '0;
      coreSync <= '0;
      probeMeta <= '0;
      probeSync <= '0;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
      coreMeta <= coreOut;
      coreSync <= coreMeta;
      probeMeta <= probeCore;
      probeSync <= probeMeta;
    end
  end

  // ==========================================================
  // link domain: state machine
  // ==========================================================
  tap_state_t state;
  always_ff @(posedge tck or negedge trstn) begin
    if (!trstn) state <= TLR;
    else begin
      case (state)
        TLR: state <= tms ? TLR : RTI;
        RTI: state <= tms ? SDS : RTI;
        SDS: state <= tms ? SIS : CDR;
        CDR: state <= tms ? E1D : SDR;
        SDR: state <= tms ? E1D : SDR;
        E1D: state <= tms ? UDR : PDR;
        PDR: state <= tms ? E2D : PDR;
        E2D: state <= tms ? UDR : SDR;
        UDR: state <= tms ? SDS : RTI;
        SIS: state <= tms ? TLR : CIR;
        CIR: state <= tms ? E1I : SIR;
        SIR: state <= tms ? E1I : SIR;
        E1I: state <= tms ? UIR : PIR;
        PIR: state <= tms ? E2I : PIR;
        E2I: state <= tms ? UIR : SIR;
        UIR: state <= tms ? SDS : RTI;
        default: state <= TLR;
      endcase
    end
  end

  // ==========================================================
  // instruction register
  // ==========================================================
  logic [IR_LEN-1:0] irShift, irCode;
  // decode to an effective instruction; anything unknown falls to bypass
  function automatic logic [IR_LEN-1:0] decode(input logic [IR_LEN-1:0] op,
                                               input logic big, input logic busy);
    logic [IR_LEN-1:0] r;
    r = OP_BYPASS;
    case (op)
      OP_ANALYZER: r = OP_ANALYZER;
      OP_IDCODE, OP_USERCODE: r = big ? OP_BYPASS : op;
      OP_EXTEST, OP_SAMPLE, OP_CFG: r = (big || busy) ? OP_BYPASS : op;
      default: r = OP_BYPASS;
    endcase
    return r;
  endfunction : decode
  // boundary instructions share the boundary register
  function automatic logic isBoundary(input logic [IR_LEN-1:0] code);
    return (code == OP_EXTEST) || (code == OP_SAMPLE);
  endfunction : isBoundary
  always_ff @(posedge tck or negedge trstn) begin
    if (!trstn) begin
      irShift <= '0;
      irCode <= LARGEST ? OP_BYPASS : OP_IDCODE;
    end else begin
      if (state == TLR) irCode <= LARGEST ? OP_BYPASS : OP_IDCODE;
      else if (state == UIR) irCode <= irShift;
      if (state == CIR) irShift <= {{(IR_LEN-2){1'b0}}, IR_CAPTURE};
      else if (state == SIR) irShift <= {tdi, irShift[IR_LEN-1:1]};
    end
  end
  logic [IR_LEN-1:0] op;
  assign op = decode(irCode, LARGEST, busyTck);

  // ==========================================================
  // data registers
  // ==========================================================
  logic bypassBit;
  logic [ID_LEN-1:0] idShift;
  logic [USER_LEN-1:0] userShift;
  logic [BSR_LEN-1:0] bsrShift, bsrUpd;
  logic [CFG_LEN-1:0] cfgShift;
  logic [DBG_LEN-1:0] dbgShift;
  always_ff @(posedge tck or negedge trstn) begin
    if (!trstn) begin
      bypassBit <= 1'b0;
      idShift <= '0;
      userShift <= '0;
      bsrShift <= '0;
      cfgShift <= '0;
      dbgShift <= '0;
    end else if (state == CDR) begin
      bypassBit <= 1'b0;
      idShift <= {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
      userShift <= USER_RESET;
      bsrShift <= {coreSync, pinSync};
      dbgShift <= probeSync;
    end else if (state == SDR) begin
      case (op)
        OP_IDCODE: idShift <= {tdi, idShift[ID_LEN-1:1]};
        OP_USERCODE: userShift <= {tdi, userShift[USER_LEN-1:1]};
        OP_EXTEST, OP_SAMPLE: bsrShift <= {tdi, bsrShift[BSR_LEN-1:1]};
        OP_CFG: cfgShift <= {tdi, cfgShift[CFG_LEN-1:1]};
        OP_ANALYZER: dbgShift <= {tdi, dbgShift[DBG_LEN-1:1]};
        default: bypassBit <= tdi;
      endcase
    end
  end

  // update stage: preload pattern and configuration byte
  logic cfgToggle;
  always_ff @(posedge tck or negedge trstn) begin
    if (!trstn) begin
      bsrUpd <= '0;
      cfgData <= '0;
      cfgToggle <= 1'b0;
    end else if (state == UDR) begin
      if (isBoundary(op)) bsrUpd <= bsrShift;
      if (op == OP_CFG) begin
        cfgData <= cfgShift;
        cfgToggle <= ~cfgToggle;
      end
    end
  end

  // pins: only extest overrides the core, sample leaves them alone
  always_ff @(posedge tck or negedge trstn) begin
    if (!trstn) begin
      pinOut <= '0;
      scanHold <= 1'b0;
    end else begin
      scanHold <= (op == OP_EXTEST);
      pinOut <= (op == OP_EXTEST) ? bsrUpd[BSR_LEN-1:PINS] : coreSync;
    end
  end

  // serial output changes on the falling edge so the tester samples cleanly
  logic serialBit;
  always_comb begin
    serialBit = irShift[0];
    if (state == SDR) begin
      case (op)
        OP_IDCODE: serialBit = idShift[0];
        OP_USERCODE: serialBit = userShift[0];
        OP_EXTEST, OP_SAMPLE: serialBit = bsrShift[0];
        OP_CFG: serialBit = cfgShift[0];
        OP_ANALYZER: serialBit = dbgShift[0];
        default: serialBit = bypassBit;
      endcase
    end
  end
  always_ff @(negedge tck or negedge trstn) begin
    if (!trstn) begin
      tdo <= 1'b0;
      tdoEn <= 1'b0;
    end else begin
      tdo <= serialBit;
      tdoEn <= (state == SDR) || (state == SIR);
    end
  end

  // ==========================================================
  // configuration strobe into the core clock domain
  // ==========================================================
  logic tglMeta, tglSync, tglLast;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tglMeta <= 1'b0;
      tglSync <= 1'b0;
      tglLast <= 1'b0;
      cfgStrobe <= 1'b0;
    end else begin
      tglMeta <= cfgToggle;
      tglSync <= tglMeta;
      tglLast <= tglSync;
      cfgStrobe <= tglSync ^ tglLast;
    end
  end
endmodule : tap_port
`default_nettype wire

// File: tb/tap_port_assertions.sv
/* port checker for tap_port.
   assumes tck stands still while trstn is low except for one pulse. */
`timescale 1ns/1ns
`default_nettype none
module tap_port_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic trstn,
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdoEn,
  input wire logic [tap_pkg::PINS-1:0] coreOut,
  input wire logic [tap_pkg::PINS-1:0] pinOut,
  input wire logic configBusy,
  input wire logic cfgStrobe,
  input wire logic scanHold
);
  // ====
  // state walks from test-logic-reset
  sequence s_reset; tms [*5]; endsequence
  sequence s_to_ir; !tms ##1 tms [*2] ##1 !tms [*2]; endsequence
  sequence s_to_dr; !tms ##1 tms ##1 !tms [*2]; endsequence
  // a high tms never leads into a shift state
  property p_no_drive; @(posedge tck) disable iff (!trstn) tms |=> !tdoEn; endproperty
  a_no_drive: assert property (p_no_drive) else $error("tdo driven outside shift");
  property p_ir_cap;
    @(posedge tck) disable iff (!trstn) s_reset ##1 s_to_ir |=> tdoEn && tdo;
  endproperty
  a_ir_cap: assert property (p_ir_cap) else $error("ir capture bit0 not one");
  property p_id_lsb;
    @(posedge tck) disable iff (!trstn) s_reset ##1 s_to_dr |=> tdoEn && tdo;
  endproperty
  a_id_lsb: assert property (p_id_lsb) else $error("id first bit not one");
  property p_trst; @(posedge tck) !trstn |-> !tdoEn && pinOut == '0; endproperty
  a_trst: assert property (p_trst) else $error("outputs not cleared in reset");
  property p_pin_pass;
    @(posedge tck) disable iff (!trstn)
      $past(trstn, 3) && !scanHold && !$past(scanHold) |-> pinOut == $past(coreOut, 3);
  endproperty
  a_pin_pass: assert property (p_pin_pass) else $error("pins disturbed");
  // the synchroniser plus update needs a few edges, six is ample
  property p_busy; @(posedge tck) disable iff (!trstn) configBusy [*6] |-> !scanHold; endproperty
  a_busy: assert property (p_busy) else $error("extest during configuration");
  property p_hold_rst; @(posedge tck) disable iff (!trstn) s_reset |-> ##3 !scanHold; endproperty
  a_hold_rst: assert property (p_hold_rst) else $error("extest survives reset");
  property p_cfg_pulse; @(posedge clk) disable iff (!resetn) cfgStrobe |=> !cfgStrobe; endproperty
  a_cfg_pulse: assert property (p_cfg_pulse) else $error("config strobe too long");
endmodule : tap_port_assertions
bind tap_port tap_port_assertions i_chk (.clk(clk), .resetn(resetn), .tck(tck), .trstn(trstn),
  .tms(tms), .tdo(tdo), .tdoEn(tdoEn), .coreOut(coreOut), .pinOut(pinOut),
  .configBusy(configBusy), .cfgStrobe(cfgStrobe), .scanHold(scanHold));
`default_nettype wire

// File: tb/jtag_tester.sv
/* behavioural test controller driving the four-wire port.
   assumes scans start from run-test-idle. */
`timescale 1ns/1ns
`default_nettype none
module jtag_tester (
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input wire logic tdo
);
  // ====
  // tck idles low between frames; tdi toggles when not shifting
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // drive in the low phase, read tdo just before the rising edge
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #62;
    o = tdo;
    tck = 1'b1;
    #63;
    tck = 1'b0;
  endtask : step
  task automatic reset5;
    logic o;
    repeat (5) step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask : reset5
  task automatic scan(input bit ir, input int n, input logic [32:0] din,
                      output logic [32:0] dout);
    logic o;
    dout = '0;
    step(1'b1, ~tdi, o);
    if (ir) step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask : scan
endmodule : jtag_tester
`default_nettype wire

// File: tb/tap_port_tb.sv
/* self-checking bench for tap_port with the tester model.
   assumes default LARGEST of zero. */
`timescale 1ns/1ns
`default_nettype none
module tap_port_tb;
  import tap_pkg::*;
  logic clk, resetn, trstn, tdo, tdoEn, tck, tms, tdi, configBusy, cfgStrobe, scanHold;
  logic [PINS-1:0] pinIn, coreOut, pinOut;
  logic [DBG_LEN-1:0] probeNodes;
  logic [CFG_LEN-1:0] cfgData;
  logic [31:0] rnd = 32'h4d70bc02;
  logic [32:0] got;
  int errCount = 0, checksDone = 0, cycles = 0, strobes = 0;
  tap_port i_dut (.clk(clk), .resetn(resetn), .tck(tck), .trstn(trstn), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoEn(tdoEn), .pinIn(pinIn), .coreOut(coreOut), .pinOut(pinOut),
    .configBusy(configBusy), .probeNodes(probeNodes), .cfgData(cfgData),
    .cfgStrobe(cfgStrobe), .scanHold(scanHold));
  jtag_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  // ====
  // clock, strobe count and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cfgStrobe === 1'b1) strobes++;
    cycles++;
    if (cycles == 30000) begin
      errCount++;
      stopTest();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [32:0] expId();
    return {1'b0, ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  endfunction : expId
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    checksDone++;
    if (g !== e) begin
      errCount++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic setin(input logic [15:0] r, input logic busy);
    @(posedge clk);
    #1;
    {probeNodes, coreOut, pinIn} = r;
    configBusy = busy;
  endtask : setin
  task automatic ir(input logic [3:0] op);
    i_tester.scan(1'b1, 4, 33'(op), got);
    chk(got & 33'hf, 33'h1);
  endtask : ir
  // one idle edge lets instruction-driven outputs follow an update
  task automatic idle;
    logic o;
    i_tester.step(1'b0, 1'b0, o);
  endtask : idle
  task automatic stopTest;
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stopTest
  // ====
  // main sequence
  initial begin
    {resetn, trstn, pinIn, coreOut, configBusy, probeNodes} = '0;
    repeat (2) @(posedge clk);
    i_tester.step(1'b1, 1'b0, got[0]);
    setin(16'h0, 1'b0);
    {resetn, trstn} = 2'b11;
    i_tester.reset5();
    i_tester.scan(1'b0, 32, 33'h0, got);
    chk(got, expId());
    ir(OP_USERCODE);
    i_tester.scan(1'b0, 32, 33'h0, got);
    chk(got, 33'(USER_RESET));
    // unassigned codes and the all-ones code all pass one stage late
    for (int op = 6; op < 16; op++) begin
      ir(4'(op));
      rnd = lfsr(rnd);
      i_tester.scan(1'b0, 33, {1'b0, rnd}, got);
      chk(got, {rnd, 1'b0});
    end
    rnd = lfsr(rnd);
    setin(rnd[15:0], 1'b0);
    ir(OP_SAMPLE);
    i_tester.scan(1'b0, 8, 33'(rnd[23:16]), got);
    chk(got, 33'({coreOut, pinIn}));
    chk(33'(pinOut), 33'(coreOut));
    ir(OP_EXTEST);
    idle();
    chk(33'({scanHold, pinOut}), 33'({1'b1, rnd[23:20]}));
    i_tester.scan(1'b0, 8, 33'(rnd[31:24]), got);
    chk(got, 33'({coreOut, pinIn}));
    idle();
    chk(33'(pinOut), 33'(rnd[31:28]));
    i_tester.reset5();
    idle();
    chk(33'(scanHold), 33'h0);
    ir(OP_EXTEST);
    idle();
    chk(33'(scanHold), 33'h1);
    setin(rnd[15:0], 1'b1);
    ir(OP_EXTEST);
    i_tester.scan(1'b0, 9, 33'h1fe, got);
    chk(33'({scanHold, got[8:0]}), 33'h1fc);
    setin(rnd[15:0], 1'b0);
    strobes = 0;
    ir(OP_CFG);
    i_tester.scan(1'b0, 8, 33'(rnd[7:0]), got);
    repeat (10) @(posedge clk);
    chk(33'({strobes[1:0], cfgData}), 33'({2'd1, rnd[7:0]}));
    rnd = lfsr(rnd);
    setin(rnd[15:0], 1'b0);
    ir(OP_ANALYZER);
    i_tester.scan(1'b0, 8, 33'h0, got);
    chk(got, 33'(probeNodes));
    stopTest();
  end
endmodule : tap_port_tb
`default_nettype wire
